//--- design/ebmiop_port.sv
// Function
// - eight pins, each pin's direction set on its own.
// - reset leaves every pin plain port, input, output, pull-up off.
// - pin is a plain port when both function-select bits are zero.
// - a one in the owning function register hands the pin over.
// - selected interrupt with input enabled stays live in stop despite drive-off.
// - outside stop, interrupt input follows pin when input enabled.
// - data register at zero, bits seven to zero, upper bits read zero.
// - output control bit one enables the driver; upper bits zero.
// - function one bits seven to zero pick interrupt, serial, reserved, async serial uses.
// - function two holds only bit two, clear-to-send two; rest zero.
// - open-drain and pull-up registers at their fixed offsets.
// - input control register at its fixed offset.
`timescale 1ns/1ps
module ebmiop_port
   import ebmiop_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_mode,
   input wire logic stop_pin_drive_keep,
   input wire logic [PIN_W-1:0] pin_in,
   output ebmiop_pad_type pad_o,
   input wire ebmiop_alt_drive_type alt_drive,
   output ebmiop_alt_in_type alt_in
);

   // ---------------------------------------------------------------
   // decode helper
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   wire wr_ok;
   wire rd_ok;

   ebmiop_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ---------------------------------------------------------------
   // write decode; only byte lane zero carries pin bits
   // ---------------------------------------------------------------
   wire lane0 = wr_en & wr_strb[0];
   wire w_hit_data = hit(wr_addr, OFF_PIN_DATA);
   wire w_hit_oe = hit(wr_addr, OFF_OUTPUT_ENABLE);
   wire w_hit_fs1 = hit(wr_addr, OFF_FUNC_SEL_ONE);
   wire w_hit_fs2 = hit(wr_addr, OFF_FUNC_SEL_TWO);
   wire w_hit_od = hit(wr_addr, OFF_OPEN_DRAIN);
   wire w_hit_pup = hit(wr_addr, OFF_PULL_UP);
   wire w_hit_ie = hit(wr_addr, OFF_INPUT_ENABLE);
   assign wr_ok = w_hit_data | w_hit_oe | w_hit_fs1 | w_hit_fs2 |
                  w_hit_od | w_hit_pup | w_hit_ie;
   wire [PIN_W-1:0] wbyte = wr_data[PIN_W-1:0];

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pin_data_reg_q;
   logic [PIN_W-1:0] output_enable_reg_q;
   logic [PIN_W-1:0] function_select_one_reg_q;
   logic [PIN_W-1:0] function_select_two_reg_q;
   logic [PIN_W-1:0] open_drain_reg_q;
   logic [PIN_W-1:0] pull_up_reg_q;
   logic [PIN_W-1:0] input_enable_reg_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_data_reg_q <= RST_PIN_DATA;
         output_enable_reg_q <= RST_OUTPUT_ENABLE;
         function_select_one_reg_q <= RST_FUNC_SEL_ONE;
         function_select_two_reg_q <= RST_FUNC_SEL_TWO;
      end
      else
      begin
         if (lane0 & w_hit_data)
            pin_data_reg_q <= wbyte;
         if (lane0 & w_hit_oe)
            output_enable_reg_q <= wbyte;
         if (lane0 & w_hit_fs1)
            function_select_one_reg_q <= wbyte;
         if (lane0 & w_hit_fs2)
            function_select_two_reg_q <= wbyte & FUNC_SEL_TWO_MASK;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         open_drain_reg_q <= RST_OPEN_DRAIN;
         pull_up_reg_q <= RST_PULL_UP;
         input_enable_reg_q <= RST_INPUT_ENABLE;
      end
      else
      begin
         if (lane0 & w_hit_od)
            open_drain_reg_q <= wbyte;
         if (lane0 & w_hit_pup)
            pull_up_reg_q <= wbyte;
         if (lane0 & w_hit_ie)
            input_enable_reg_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // pin sampling
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pin_sync;

   ebmiop_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ---------------------------------------------------------------
   // stop mode: drive-off cuts drivers and peripheral inputs; data reads still see the pin
   // ---------------------------------------------------------------
   wire stop_cut = stop_mode & stop_pin_drive_keep;
   wire [PIN_W-1:0] stop_mask = stop_cut ? {PIN_W{1'b0}} : {PIN_W{1'b1}};

   // input buffer gate; a disabled buffer gives a fixed value
   wire [PIN_W-1:0] in_live = pin_sync & input_enable_reg_q & stop_mask;

   // interrupt line: live on input enable outside stop, and in stop
   // with drive-off only when the function is selected too
   wire int_sel_live = function_select_one_reg_q[BIT_INT_FIVE] &
                       input_enable_reg_q[BIT_INT_FIVE];
   wire int_in_live = input_enable_reg_q[BIT_INT_FIVE] &
                      (~stop_cut | int_sel_live);
   wire int_five_d = pin_sync[BIT_INT_FIVE] & int_in_live;

   // ---------------------------------------------------------------
   // function routing
   // ---------------------------------------------------------------
   // first register wins if both are set for one pin
   wire [PIN_W-1:0] sel_one = function_select_one_reg_q;
   wire [PIN_W-1:0] sel_two = function_select_two_reg_q & ~sel_one;
   wire [PIN_W-1:0] sel_port = ~(sel_one | sel_two);
   wire [PIN_W-1:0] alt_ok = sel_one & ~FUNC_SEL_ONE_RSVD;

   // driver enable and level per pin
   wire [PIN_W-1:0] drv_en_raw = (sel_port & output_enable_reg_q) |
                                 (alt_ok & alt_drive.en);
   wire [PIN_W-1:0] drv_en = drv_en_raw & stop_mask;
   wire [PIN_W-1:0] drv_val = (sel_port & pin_data_reg_q) |
                              (alt_ok & alt_drive.out);

   // open drain drives only a low level
   wire [PIN_W-1:0] od_drive = drv_en & ~drv_val;
   wire [PIN_W-1:0] oe_n_d = ~((drv_en & ~open_drain_reg_q) |
                               (od_drive & open_drain_reg_q));
   wire [PIN_W-1:0] out_d = drv_val & ~open_drain_reg_q;

   // inputs handed to the serial peripherals
   wire [PIN_W-1:0] alt_in_d = in_live & alt_ok;
   wire cts_two_d = in_live[BIT_CTS_TWO] & sel_two[BIT_CTS_TWO];

   // ---------------------------------------------------------------
   // registered pad and peripheral outputs
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad_o.out <= '0;
         pad_o.oe_n <= '1;
         pad_o.pull_up <= '0;
         alt_in <= '0;
      end
      else
      begin
         pad_o.out <= out_d;
         pad_o.oe_n <= oe_n_d;
         pad_o.pull_up <= pull_up_reg_q;
         alt_in.in <= alt_in_d;
         alt_in.cts_two <= cts_two_d;
         alt_in.int_five <= int_five_d;
      end
   end

   // ---------------------------------------------------------------
   // read decode; unused upper bits read zero
   // ---------------------------------------------------------------
   wire r_hit_data = hit(rd_addr, OFF_PIN_DATA);
   wire r_hit_oe = hit(rd_addr, OFF_OUTPUT_ENABLE);
   wire r_hit_fs1 = hit(rd_addr, OFF_FUNC_SEL_ONE);
   wire r_hit_fs2 = hit(rd_addr, OFF_FUNC_SEL_TWO);
   wire r_hit_od = hit(rd_addr, OFF_OPEN_DRAIN);
   wire r_hit_pup = hit(rd_addr, OFF_PULL_UP);
   wire r_hit_ie = hit(rd_addr, OFF_INPUT_ENABLE);
   assign rd_ok = r_hit_data | r_hit_oe | r_hit_fs1 | r_hit_fs2 |
                  r_hit_od | r_hit_pup | r_hit_ie;

   // data reads the pin where the buffer is on, else the fixed value
   wire [PIN_W-1:0] data_view = (pin_sync & input_enable_reg_q) |
                                (INPUT_OFF_VALUE & ~input_enable_reg_q);

   wire [PIN_W-1:0] rd_byte =
      ({PIN_W{r_hit_data}} & data_view) |
      ({PIN_W{r_hit_oe}} & output_enable_reg_q) |
      ({PIN_W{r_hit_fs1}} & function_select_one_reg_q) |
      ({PIN_W{r_hit_fs2}} & function_select_two_reg_q) |
      ({PIN_W{r_hit_od}} & open_drain_reg_q) |
      ({PIN_W{r_hit_pup}} & pull_up_reg_q) |
      ({PIN_W{r_hit_ie}} & input_enable_reg_q);

   assign rd_data = {{(DATA_W-PIN_W){1'b0}}, rd_byte};

endmodule // ebmiop_port

//--- shared/ebmiop_pkg.sv
package ebmiop_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int PIN_W = 8;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_PIN_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_OUTPUT_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FUNC_SEL_ONE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FUNC_SEL_TWO = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_OPEN_DRAIN = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_PULL_UP = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_INPUT_ENABLE = 8'h38;

   // ---------------------------------------------------------------
   // reset values and field layout
   // ---------------------------------------------------------------
   localparam logic [PIN_W-1:0] RST_PIN_DATA = 8'h00;
   localparam logic [PIN_W-1:0] RST_OUTPUT_ENABLE = 8'h00;
   localparam logic [PIN_W-1:0] RST_FUNC_SEL_ONE = 8'h00;
   localparam logic [PIN_W-1:0] RST_FUNC_SEL_TWO = 8'h00;
   localparam logic [PIN_W-1:0] RST_OPEN_DRAIN = 8'h00;
   localparam logic [PIN_W-1:0] RST_PULL_UP = 8'h00;
   localparam logic [PIN_W-1:0] RST_INPUT_ENABLE = 8'h00;
   localparam logic [PIN_W-1:0] FUNC_SEL_TWO_MASK = 8'h04;
   localparam logic [PIN_W-1:0] FUNC_SEL_ONE_RSVD = 8'h08;
   localparam logic [PIN_W-1:0] INPUT_OFF_VALUE = 8'h00;
   localparam int BIT_INT_FIVE = 7;
   localparam int BIT_CTS_TWO = 2;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // carriers and states
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] out;
      logic [PIN_W-1:0] oe_n;
      logic [PIN_W-1:0] pull_up;
   } ebmiop_pad_type;

   typedef struct packed {
      logic [PIN_W-1:0] out;
      logic [PIN_W-1:0] en;
   } ebmiop_alt_drive_type;

   typedef struct packed {
      logic [PIN_W-1:0] in;
      logic cts_two;
      logic int_five;
   } ebmiop_alt_in_type;

   typedef enum logic [4:0] {
      WR_IDLE = 5'h01,
      WR_ADDR = 5'h02,
      WR_DATA = 5'h04,
      WR_EXEC = 5'h08,
      WR_RESP = 5'h10
   } ebmiop_wr_state_type;

endpackage

//--- design/ebmiop_sync.sv
`timescale 1ns/1ps
module ebmiop_sync
   import ebmiop_pkg::*;
#(
   parameter int WIDTH = PIN_W
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // second stage is the only reader of the first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // ebmiop_sync

//--- design/ebmiop_axil_slave.sv
`timescale 1ns/1ps
module ebmiop_axil_slave
   import ebmiop_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [DATA_W-1:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic rd_ok
);

   ebmiop_wr_state_type state_q;
   ebmiop_wr_state_type state_d;
   logic rd_go_q;
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;

   // ---------------------------------------------------------------
   // write sequence: address and data in either order
   // ---------------------------------------------------------------
   always_comb
   begin
      case (state_q)
         WR_IDLE: state_d = (aw_take & w_take) ? WR_EXEC :
                            aw_take ? WR_ADDR : w_take ? WR_DATA : WR_IDLE;
         WR_ADDR: state_d = w_take ? WR_EXEC : WR_ADDR;
         WR_DATA: state_d = aw_take ? WR_EXEC : WR_DATA;
         WR_EXEC: state_d = WR_RESP;
         WR_RESP: state_d = bready ? WR_IDLE : WR_RESP;
         default: state_d = WR_IDLE;
      endcase
   end

   assign wr_en = (state_q == WR_EXEC);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= WR_IDLE;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end
      else
      begin
         state_q <= state_d;
         awready <= (state_d == WR_IDLE) | (state_d == WR_DATA);
         wready <= (state_d == WR_IDLE) | (state_d == WR_ADDR);
         if (aw_take)
            wr_addr <= awaddr;
         if (w_take)
         begin
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en)
         begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read: one outstanding, answer two cycles after the take
   // ---------------------------------------------------------------
   assign rd_en = rd_go_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rd_go_q <= 1'b0;
         rd_addr <= '0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else
      begin
         rd_go_q <= arvalid & arready;
         if (arvalid & arready)
         begin
            rd_addr <= araddr;
            arready <= 1'b0;
         end
         if (rd_go_q)
         begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid & rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule // ebmiop_axil_slave

//--- sim/ebmiop_port_props.sv
`timescale 1ns/1ps
module ebmiop_port_chk
   import ebmiop_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic stop_mode,
   input wire logic stop_pin_drive_keep,
   input wire logic [PIN_W-1:0] pin_in,
   input wire ebmiop_pad_type pad_o,
   input wire ebmiop_alt_in_type alt_in
);
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire stop_off = stop_mode && stop_pin_drive_keep;

   chk_reset_pads: assert property (
      $rose(aresetn) |-> pad_o.oe_n == 8'hFF && pad_o.pull_up == 8'h00)
      else $error("pads not released after reset");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer not two edges after take");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer not two edges after take");
   chk_write_refused: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("write address taken while busy");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   chk_unmapped_read: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
      |-> ##2 s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   chk_stop_release: assert property (
      stop_off [*2] |-> pad_o.oe_n == 8'hFF)
      else $error("pin driven in stop with drive off");
   chk_stop_inputs: assert property (
      stop_off [*4] |-> alt_in.in == 8'h00 && !alt_in.cts_two)
      else $error("peripheral input live in stop");
   chk_int_source: assert property (
      alt_in.int_five |-> $past(pin_in[7], 3))
      else $error("interrupt line without pin level");
   chk_alt_source: assert property (
      (alt_in.in & ~$past(pin_in, 3)) == 8'h00 && !alt_in.in[3])
      else $error("peripheral input without pin level");
   chk_cts_source: assert property (
      alt_in.cts_two |-> $past(pin_in[2], 3))
      else $error("clear to send without pin level");
endmodule // ebmiop_port_chk

bind ebmiop_port ebmiop_port_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .stop_mode,
   .stop_pin_drive_keep, .pin_in, .pad_o, .alt_in);

//--- sim/ebmiop_pins_model.sv
`timescale 1ns/1ps
module ebmiop_pins_model
   import ebmiop_pkg::*;
(
   input wire logic aclk,
   input wire ebmiop_pad_type pad_o,
   input wire logic [PIN_W-1:0] ext_drive,
   input wire logic [PIN_W-1:0] ext_level,
   output logic [PIN_W-1:0] pin_in
);
   // ------------------------------------------------------------
   // pad wire resolution
   // ------------------------------------------------------------
   logic [PIN_W-1:0] float_q = 8'h55;
   wire [PIN_W-1:0] pad_drv = ~pad_o.oe_n;
   wire [PIN_W-1:0] ext_drv = pad_o.oe_n & ext_drive;
   wire [PIN_W-1:0] idle = pad_o.oe_n & ~ext_drive;

   // undriven pins without pull-up wander so a stale level never passes
   always @(posedge aclk)
      float_q <= ~float_q;

   assign pin_in = (pad_drv & pad_o.out) | (ext_drv & ext_level)
      | (idle & pad_o.pull_up) | (idle & ~pad_o.pull_up & float_q);
endmodule // ebmiop_pins_model

//--- sim/test_eight_bit_muxed_io_port.sv
`timescale 1ns/1ps
module test_eight_bit_muxed_io_port
   import ebmiop_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, stop_mode = 1'b0, stop_pin_drive_keep = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [DATA_W-1:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [2:0] prot_tie = 3'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [PIN_W-1:0] pin_in, ext_drive = 8'h00, ext_level = 8'h00;
   ebmiop_pad_type pad_o;
   ebmiop_alt_drive_type alt_drive = 16'h0000;
   ebmiop_alt_in_type alt_in;
   int fail_count = 0, comparisons = 0;
   logic [7:0] offs [7] = '{OFF_PIN_DATA, OFF_OUTPUT_ENABLE, OFF_FUNC_SEL_ONE,
      OFF_FUNC_SEL_TWO, OFF_OPEN_DRAIN, OFF_PULL_UP, OFF_INPUT_ENABLE};
   logic [31:0] back [7] = '{32'h00, 32'hA6, 32'hA6, 32'h04, 32'hA6, 32'hA6, 32'hA6};

   always #10 aclk = ~aclk;

   ebmiop_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(prot_tie),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(prot_tie), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .stop_pin_drive_keep,
      .pin_in, .pad_o, .alt_drive, .alt_in);
   ebmiop_pins_model u_pins (.aclk, .pad_o, .ext_drive, .ext_level, .pin_in);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, input logic [31:0] ed);
      bit dn;
      int n;
      dn = 1'b0;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_bready <= w;
      s_axi_rready <= !w;
      while (!dn && n < 40)
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (w ? s_axi_bvalid : s_axi_rvalid)
         begin
            dn = 1'b1;
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            chk(32'(w ? s_axi_bresp : s_axi_rresp), 32'(er));
            if (!w) chk(s_axi_rdata, ed);
         end
      end
      if (!dn)
      begin
         fail_count++;
         test_done();
      end
   endtask

   task automatic settle();
      repeat (4) @(posedge aclk);
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) bus(1'b0, offs[i], 32'h0, RESP_OKAY, 32'h0);
      chk(32'(pad_o), 32'h00FF00);
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b1, offs[i], 32'hFFFFFFA6, RESP_OKAY, 32'h0);
         bus(1'b0, offs[i], 32'h0, RESP_OKAY, back[i]);
         bus(1'b1, offs[i], 32'h0, RESP_OKAY, 32'h0);
      end
      bus(1'b1, 8'h10, 32'hFF, RESP_SLVERR, 32'h0);
      bus(1'b0, 8'h10, 32'h0, RESP_SLVERR, 32'h0);
      // port mode: low nibble driven, high nibble from outside
      ext_level <= 8'h50;
      ext_drive <= 8'hF0;
      bus(1'b1, OFF_PIN_DATA, 32'hA6, RESP_OKAY, 32'h0);
      bus(1'b1, OFF_OUTPUT_ENABLE, 32'h0F, RESP_OKAY, 32'h0);
      bus(1'b1, OFF_INPUT_ENABLE, 32'hFF, RESP_OKAY, 32'h0);
      settle();
      chk(32'(pad_o.oe_n), 32'hF0);
      chk(32'(pad_o.out & ~pad_o.oe_n), 32'h06);
      s_axi_wstrb <= 4'hE;
      bus(1'b1, OFF_OUTPUT_ENABLE, 32'hFF, RESP_OKAY, 32'h0);
      s_axi_wstrb <= 4'hF;
      bus(1'b0, OFF_OUTPUT_ENABLE, 32'h0, RESP_OKAY, 32'h0F);
      bus(1'b0, OFF_PIN_DATA, 32'h0, RESP_OKAY, 32'h56);
      bus(1'b1, OFF_OPEN_DRAIN, 32'h03, RESP_OKAY, 32'h0);
      bus(1'b1, OFF_PULL_UP, 32'h03, RESP_OKAY, 32'h0);
      settle();
      chk(32'(pad_o.oe_n[1:0]), 32'h2);
      chk(32'(pad_o.pull_up), 32'h03);
      bus(1'b0, OFF_PIN_DATA, 32'h0, RESP_OKAY, 32'h56);
      // alternate functions, every pin pulled high from outside
      ext_drive <= 8'hFF;
      ext_level <= 8'hFF;
      bus(1'b1, OFF_OUTPUT_ENABLE, 32'h0, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.in), 32'h0);
      for (int b = 0; b < 8; b++)
      begin
         bus(1'b1, OFF_FUNC_SEL_ONE, 32'(1 << b), RESP_OKAY, 32'h0);
         settle();
         chk(32'(alt_in.in), (b == 3) ? 32'h0 : 32'(1 << b));
      end
      bus(1'b1, OFF_FUNC_SEL_ONE, 32'h01, RESP_OKAY, 32'h0);
      alt_drive <= 16'h0001;
      settle();
      chk(32'({pad_o.oe_n[0], pad_o.out[0]}), 32'h0);
      alt_drive <= 16'h0000;
      bus(1'b1, OFF_FUNC_SEL_ONE, 32'h0, RESP_OKAY, 32'h0);
      bus(1'b1, OFF_FUNC_SEL_TWO, 32'h04, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.cts_two), 32'h1);
      bus(1'b1, OFF_INPUT_ENABLE, 32'hFB, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.cts_two), 32'h0);
      chk(32'(alt_in.int_five), 32'h1);
      // stop with pin drive cut
      stop_mode <= 1'b1;
      stop_pin_drive_keep <= 1'b1;
      settle();
      chk(32'(alt_in.int_five), 32'h0);
      chk(32'(pad_o.oe_n), 32'hFF);
      bus(1'b1, OFF_FUNC_SEL_ONE, 32'h80, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.int_five), 32'h1);
      ext_level <= 8'h7F;
      settle();
      chk(32'(alt_in.int_five), 32'h0);
      stop_pin_drive_keep <= 1'b0;
      ext_level <= 8'hFF;
      bus(1'b1, OFF_FUNC_SEL_ONE, 32'h0, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.int_five), 32'h1);
      chk(32'(pad_o.oe_n), 32'hFF);
      stop_mode <= 1'b0;
      bus(1'b1, OFF_INPUT_ENABLE, 32'h7B, RESP_OKAY, 32'h0);
      settle();
      chk(32'(alt_in.int_five), 32'h0);
      test_done();
   end
endmodule // test_eight_bit_muxed_io_port
